// ===== gp_pkg.sv
// Shared constants for the global parameter command handler
package gp_pkg;
  // Command frame layout
  localparam int        FRAME_LEN     = 9;
  localparam int        DATA_W        = 32;
  localparam int        MEM_AW        = 10;
  localparam logic [3:0] LAST_BYTE    = 4'h8;
  // Instruction codes
  localparam logic [7:0] INSTR_SET     = 8'h09;
  localparam logic [7:0] INSTR_GET     = 8'h0A;
  localparam logic [7:0] INSTR_STORE   = 8'h0B;
  localparam logic [7:0] INSTR_RESTORE = 8'h0C;
  // Bank numbers
  localparam logic [7:0] BANK_MODULE   = 8'h00;
  localparam logic [7:0] BANK_USER     = 8'h02;
  localparam logic [7:0] BANK_IRQ      = 8'h03;
  localparam logic [1:0] BANK_USER_IDX = 2'h2;
  // Module address parameter and its value after reset
  localparam logic [7:0] PARAM_ADDR    = 8'h42;
  localparam logic [7:0] ADDR_RESET    = 8'h01;
  // Reply status codes
  localparam logic [7:0] STATUS_OK      = 8'h64;
  localparam logic [7:0] STATUS_CHKSUM  = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_BANK = 8'h04;
  // Clock edges allowed for the strap synchroniser to settle
  localparam logic [1:0] STRAP_WAIT    = 2'h3;
endpackage

// ===== mem_port_if.sv
// Port bundle between the handler and one parameter memory
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if #(parameter int AW = 10, parameter int DW = 32);
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== param_ram.sv
// Single-port parameter memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module param_ram #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  input wire logic clk,
  mem_port_if.mem  port
);
  logic [DW-1:0] store [2**AW];

  // Read-before-write: a write cycle returns the old word
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end
endmodule
`default_nettype wire

// ===== global_param_command_handler.sv
// Global parameter command handler: frame decode, bank access, store and restore
// Summary of operation
// - Instruction 9 writes value into parameter type of bank 0, 2 or 3.
// - Bank 0 is module settings, bank 2 user variables, bank 3 interrupt setup.
// - Every bank 0 write is copied into non-volatile memory at once.
// - Instruction 10 reads parameter into accumulator and reply value; command value ignored.
// - Every parameter of every supported bank can be read back.
// - Instruction 11 with bank 2 copies the user variable into non-volatile memory.
// - Instruction 12 with bank 2 reloads the user variable from non-volatile memory.
// - After power-up user variables reload from non-volatile memory unless disabled.
// - Bank 0 parameter 66 holds the module address the device answers to.
`timescale 1ns/1ps
`default_nettype none
module global_param_command_handler #(
  parameter int         DW        = gp_pkg::DATA_W,
  parameter logic [7:0] ADDR_INIT = gp_pkg::ADDR_RESET
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          byte_valid,
  input  wire logic [7:0]    byte_data,
  input  wire logic          auto_restore,
  output logic               ready,
  output logic               reply_valid,
  output logic [7:0]         reply_addr,
  output logic [7:0]         reply_status,
  output logic [7:0]         reply_instr,
  output logic [DW-1:0]      reply_value,
  output logic [7:0]         module_addr,
  output logic [DW-1:0]      accum
);
  typedef enum logic [2:0] {
    S_WAIT, S_BOOT_RD, S_BOOT_WR, S_IDLE, S_GET, S_STORE, S_RESTORE
  } state_e;

  state_e                    state_reg;
  state_e                    state_next;
  logic [1:0]                wait_reg;
  logic                      strap_meta_reg;
  logic                      strap_sync_reg;
  logic [3:0]                cnt_reg;
  logic [63:0]               shift_reg;
  logic [7:0]                sum_reg;
  logic [63:0]               frame_reg;
  logic                      done_reg;
  logic                      chk_ok_reg;
  logic [7:0]                boot_idx_reg;
  logic [gp_pkg::MEM_AW-1:0] cmd_idx_reg;
  logic [7:0]                cmd_instr_reg;
  logic [7:0]                addr_reg;
  logic [DW-1:0]             accum_reg;

  mem_port_if #(.AW(gp_pkg::MEM_AW), .DW(DW)) live ();
  mem_port_if #(.AW(gp_pkg::MEM_AW), .DW(DW)) nv ();

  // Working copy of all banks; bank index in the two top address bits
  param_ram #(.AW(gp_pkg::MEM_AW), .DW(DW)) u_live (
    .clk  (clk),
    .port (live.mem)
  );

  // Non-volatile backing copy; only bank 0 and bank 2 entries are used
  param_ram #(.AW(gp_pkg::MEM_AW), .DW(DW)) u_nv (
    .clk  (clk),
    .port (nv.mem)
  );

  // Frame field split
  wire logic [7:0]    f_addr  = frame_reg[63:56];
  wire logic [7:0]    f_instr = frame_reg[55:48];
  wire logic [7:0]    f_type  = frame_reg[47:40];
  wire logic [7:0]    f_bank  = frame_reg[39:32];
  wire logic [DW-1:0] f_value = frame_reg[DW-1:0];
  wire logic [DW-1:0] live_rdata = live.rdata;
  wire logic [DW-1:0] nv_rdata   = nv.rdata;

  // Command decode; frames for other addresses are ignored silently
  wire logic in_idle    = (state_reg == S_IDLE);
  wire logic hit        = done_reg && in_idle && (f_addr == addr_reg);
  wire logic is_set     = (f_instr == gp_pkg::INSTR_SET);
  wire logic is_get     = (f_instr == gp_pkg::INSTR_GET);
  wire logic is_store   = (f_instr == gp_pkg::INSTR_STORE);
  wire logic is_restore = (f_instr == gp_pkg::INSTR_RESTORE);
  wire logic known      = is_set || is_get || is_store || is_restore;
  wire logic bank_mod   = (f_bank == gp_pkg::BANK_MODULE);
  wire logic bank_user  = (f_bank == gp_pkg::BANK_USER);
  wire logic bank_any   = bank_mod || bank_user || (f_bank == gp_pkg::BANK_IRQ);
  wire logic bank_fit   = (is_set || is_get) ? bank_any : bank_user;
  wire logic cmd_ok     = chk_ok_reg && known && bank_fit;
  wire logic do_set     = hit && cmd_ok && is_set;
  wire logic autosave   = do_set && bank_mod;
  wire logic [gp_pkg::MEM_AW-1:0] idx      = {f_bank[1:0], f_type};
  wire logic [gp_pkg::MEM_AW-1:0] boot_idx = {gp_pkg::BANK_USER_IDX, boot_idx_reg};

  // Working memory port: boot and restore copy from nv, set writes frame value
  assign live.we    = do_set || (state_reg == S_BOOT_WR) || (state_reg == S_RESTORE);
  assign live.addr  = (state_reg == S_BOOT_WR) ? boot_idx :
                      (state_reg == S_RESTORE) ? cmd_idx_reg : idx;
  assign live.wdata = in_idle ? f_value : nv_rdata;

  // Backing memory port: bank 0 writes go straight through, store copies live data
  assign nv.we    = autosave || (state_reg == S_STORE);
  assign nv.addr  = (state_reg == S_BOOT_RD) ? boot_idx :
                    (state_reg == S_STORE) ? cmd_idx_reg : idx;
  assign nv.wdata = in_idle ? f_value : live_rdata;

  // Strap synchroniser; the second stage alone is read
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= auto_restore;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Byte assembly with running sum; a frame needs all nine bytes, no timeout
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg    <= 4'h0;
      sum_reg    <= 8'h00;
      shift_reg  <= 64'h0;
      frame_reg  <= 64'h0;
      done_reg   <= 1'b0;
      chk_ok_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (byte_valid && (cnt_reg == gp_pkg::LAST_BYTE)) begin
        frame_reg  <= shift_reg;
        chk_ok_reg <= (byte_data == sum_reg);
        done_reg   <= 1'b1;
        cnt_reg    <= 4'h0;
        sum_reg    <= 8'h00;
      end else if (byte_valid) begin
        shift_reg <= {shift_reg[55:0], byte_data};
        sum_reg   <= sum_reg + byte_data;
        cnt_reg   <= cnt_reg + 4'h1;
      end
    end
  end

  // Next state: get, store and restore each take one extra memory cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_WAIT: begin
        if (wait_reg == gp_pkg::STRAP_WAIT) begin
          state_next = strap_sync_reg ? S_IDLE : S_BOOT_RD;
        end
      end
      S_BOOT_RD: state_next = S_BOOT_WR;
      S_BOOT_WR: state_next = (boot_idx_reg == 8'hFF) ? S_IDLE : S_BOOT_RD;
      S_IDLE: begin
        if (hit && cmd_ok && is_get) begin
          state_next = S_GET;
        end else if (hit && cmd_ok && is_store) begin
          state_next = S_STORE;
        end else if (hit && cmd_ok && is_restore) begin
          state_next = S_RESTORE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Sequencer registers; boot restore walks all 256 user variables
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= S_WAIT;
      wait_reg      <= 2'h0;
      boot_idx_reg  <= 8'h00;
      cmd_idx_reg   <= '0;
      cmd_instr_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == S_WAIT) begin
        wait_reg <= wait_reg + 2'h1;
      end
      if (state_reg == S_BOOT_WR) begin
        boot_idx_reg <= boot_idx_reg + 8'h01;
      end
      if (hit) begin
        cmd_idx_reg   <= idx;
        cmd_instr_reg <= f_instr;
      end
    end
  end

  // Module address and accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg  <= ADDR_INIT;
      accum_reg <= '0;
    end else begin
      if (do_set && bank_mod && (f_type == gp_pkg::PARAM_ADDR)) begin
        addr_reg <= f_value[7:0];
      end
      if (state_reg == S_GET) begin
        accum_reg <= live_rdata;
      end
    end
  end

  // Replies: errors and set answer at once, memory commands one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      reply_valid  <= 1'b0;
      reply_status <= 8'h00;
      reply_instr  <= 8'h00;
      reply_value  <= '0;
      ready        <= 1'b0;
    end else begin
      reply_valid <= 1'b0;
      ready       <= (state_next == S_IDLE);
      if (hit && (!cmd_ok || is_set)) begin
        reply_valid  <= 1'b1;
        reply_instr  <= f_instr;
        reply_value  <= '0;
        reply_status <= !chk_ok_reg ? gp_pkg::STATUS_CHKSUM :
                        !known      ? gp_pkg::STATUS_BAD_CMD :
                        !bank_fit   ? gp_pkg::STATUS_BAD_BANK : gp_pkg::STATUS_OK;
      end else if ((state_reg == S_GET) || (state_reg == S_STORE) || (state_reg == S_RESTORE)) begin
        reply_valid  <= 1'b1;
        reply_instr  <= cmd_instr_reg;
        reply_status <= gp_pkg::STATUS_OK;
        reply_value  <= (state_reg == S_GET) ? live_rdata : '0;
      end
    end
  end

  assign reply_addr  = addr_reg;
  assign module_addr = addr_reg;
  assign accum       = accum_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_set_reply_ok: assert property (do_set |=> reply_valid && reply_status == 8'h64 && reply_instr == 8'h09)
    else $error("set command did not answer ok");
  a_bank_one_refused: assert property (hit && chk_ok_reg && is_set && f_bank == 8'h01 |=> reply_status == 8'h04)
    else $error("bank 1 accepted");
  // The write must land: two edges later the backing copy reads back the value that was set
  a_bank0_autosave: assert property (autosave |-> (nv.we && nv.addr[9:8] == 2'h0) ##2 (nv_rdata == $past(f_value, 2)))
    else $error("bank 0 write not saved");
  a_get_value_path: assert property (hit && cmd_ok && is_get |=> ##1 reply_valid && reply_value == accum_reg
    && accum_reg == $past(live_rdata))
    else $error("get reply differs from memory");
  a_get_all_banks: assert property (hit && chk_ok_reg && is_get && bank_any |=> state_reg == S_GET)
    else $error("get refused on supported bank");
  a_store_copy: assert property (hit && cmd_ok && is_store |=> nv.we && nv.addr == $past(idx)
    && nv.wdata == live_rdata)
    else $error("store did not copy user variable");
  a_restore_copy: assert property (hit && cmd_ok && is_restore |=> live.we && live.wdata == nv_rdata
    && live.addr[9:8] == 2'h2)
    else $error("restore did not reload user variable");
  a_boot_restore: assert property (state_reg == S_BOOT_WR |-> $past(state_reg) == S_BOOT_RD && live.we
    && live.addr == $past(nv.addr))
    else $error("boot copy out of step");
  a_addr_update: assert property (do_set && bank_mod && f_type == 8'h42 |=> module_addr == $past(f_value[7:0]))
    else $error("module address not updated");
  a_checksum_err: assert property (hit && !chk_ok_reg |=> reply_valid && reply_status == 8'h01)
    else $error("bad checksum not reported");
endmodule
`default_nettype wire

// ===== host_frame_model.sv
// Host model: sends nine-byte command frames on the byte strobe
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
  input  wire logic       clk,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  // Idle link at time zero
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end
  // Bytes go back to back, value MSB first; a nonzero skew spoils the checksum on purpose
  task automatic send_frame(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] typ,
                            input logic [7:0] bnk, input logic [31:0] val, input logic [7:0] skew);
    logic [7:0] b [9];
    b = '{adr, ins, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
    b[8] = b[8] + skew;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #1;
      byte_valid = 1'b1;
      byte_data  = b[i];
    end
    @(posedge clk);
    #1;
    byte_valid = 1'b0;
    byte_data  = ~b[8]; // Released data must not keep showing the last byte
  endtask
endmodule
`default_nettype wire

// ===== global_param_command_handler_tb.sv
// Testbench for the global parameter command handler
`timescale 1ns/1ps
`default_nettype none
module global_param_command_handler_tb;
  logic        clk;
  logic        rst;
  logic        auto_restore;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        ready;
  logic        reply_valid;
  logic [7:0]  reply_addr;
  logic [7:0]  reply_status;
  logic [7:0]  reply_instr;
  logic [31:0] reply_value;
  logic [7:0]  module_addr;
  logic [31:0] accum;
  int          fail_count;
  int          check_count;
  localparam logic [7:0] NONE = 8'h00;

  global_param_command_handler uut (.clk(clk), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
    .auto_restore(auto_restore), .ready(ready), .reply_valid(reply_valid), .reply_addr(reply_addr),
    .reply_status(reply_status), .reply_instr(reply_instr), .reply_value(reply_value),
    .module_addr(module_addr), .accum(accum));
  host_frame_model host (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // Reset for 4 cycles, then wait for boot with a bound
  task automatic do_reset(input logic strap);
    int n;
    n = 0;
    rst = 1'b1;
    auto_restore = strap;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    while (ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(ready === 1'b1 && module_addr === gp_pkg::ADDR_RESET, "boot did not finish");
  endtask

  // One frame and its reply; st of NONE means no reply is expected
  task automatic cmd(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bnk,
                     input logic [31:0] val, input logic [7:0] skew, input logic [7:0] st, input logic [31:0] exp);
    int n;
    logic [7:0] ea;
    n = 0;
    // A successful address write answers from the new address
    ea = (ins == gp_pkg::INSTR_SET && typ == gp_pkg::PARAM_ADDR && bnk == gp_pkg::BANK_MODULE
          && st == gp_pkg::STATUS_OK) ? val[7:0] : adr;
    host.send_frame(adr, ins, typ, bnk, val, skew);
    while (reply_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (st == NONE) chk(reply_valid !== 1'b1, "unexpected reply");
    else chk(reply_valid === 1'b1 && reply_status === st && reply_instr === ins && reply_value === exp
             && reply_addr === ea, "reply wrong");
  endtask

  // Set then read back in each bank; the command value of a read is junk and must be ignored
  task automatic s_set_get;
    logic [7:0] banks [3];
    logic [31:0] v;
    banks = '{gp_pkg::BANK_MODULE, gp_pkg::BANK_USER, gp_pkg::BANK_IRQ};
    for (int i = 0; i < 3; i++) begin
      v = 32'hA55A_0000 | 32'(banks[i]);
      cmd(8'h01, gp_pkg::INSTR_SET, 8'h05, banks[i], v, 8'h00, gp_pkg::STATUS_OK, 32'h0);
      cmd(8'h01, gp_pkg::INSTR_GET, 8'h05, banks[i], 32'hFFFF_FFFF, 8'h00, gp_pkg::STATUS_OK, v);
      chk(accum === v, "accumulator not loaded");
    end
  endtask

  // Move the module address and back; the old address must go deaf
  task automatic s_address;
    cmd(8'h01, gp_pkg::INSTR_SET, gp_pkg::PARAM_ADDR, 8'h00, 32'h3, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    chk(module_addr === 8'h03, "address not changed");
    cmd(8'h01, gp_pkg::INSTR_GET, 8'h05, 8'h00, 32'h0, 8'h00, NONE, 32'h0);
    cmd(8'h03, gp_pkg::INSTR_GET, gp_pkg::PARAM_ADDR, 8'h00, 32'h0, 8'h00, gp_pkg::STATUS_OK, 32'h3);
    cmd(8'h03, gp_pkg::INSTR_SET, gp_pkg::PARAM_ADDR, 8'h00, 32'h1, 8'h00, gp_pkg::STATUS_OK, 32'h0);
  endtask

  // Store, overwrite, restore: the stored copy wins
  task automatic s_store_restore;
    cmd(8'h01, gp_pkg::INSTR_SET, 8'h2A, 8'h02, 32'h1234_5678, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_STORE, 8'h2A, 8'h02, 32'h9, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_SET, 8'h2A, 8'h02, 32'hDEAD_0001, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_GET, 8'h2A, 8'h02, 32'h0, 8'h00, gp_pkg::STATUS_OK, 32'hDEAD_0001);
    cmd(8'h01, gp_pkg::INSTR_RESTORE, 8'h2A, 8'h02, 32'h7, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_GET, 8'h2A, 8'h02, 32'h0, 8'h00, gp_pkg::STATUS_OK, 32'h1234_5678);
  endtask

  // Broken checksum and banks outside the allowed set are refused
  task automatic s_errors;
    cmd(8'h01, gp_pkg::INSTR_SET, 8'h05, 8'h00, 32'h1, 8'h01, gp_pkg::STATUS_CHKSUM, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_SET, 8'h05, 8'h01, 32'h1, 8'h00, gp_pkg::STATUS_BAD_BANK, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_STORE, 8'h05, 8'h00, 32'h0, 8'h00, gp_pkg::STATUS_BAD_BANK, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_RESTORE, 8'h05, 8'h03, 32'h0, 8'h00, gp_pkg::STATUS_BAD_BANK, 32'h0);
    cmd(8'h01, 8'h05, 8'h05, 8'h00, 32'h0, 8'h00, gp_pkg::STATUS_BAD_CMD, 32'h0);
    cmd(8'h01, gp_pkg::INSTR_GET, 8'h05, 8'h00, 32'h0, 8'h00, gp_pkg::STATUS_OK, 32'hA55A_0000);
  endtask

  // Strap low reloads the stored copy over a changed variable; strap high leaves the live value alone
  task automatic s_boot_reload;
    cmd(8'h01, gp_pkg::INSTR_SET, 8'h2A, 8'h02, 32'h0BAD_0BAD, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    do_reset(1'b0);
    cmd(8'h01, gp_pkg::INSTR_GET, 8'h2A, 8'h02, 32'h0, 8'h00, gp_pkg::STATUS_OK, 32'h1234_5678);
    cmd(8'h01, gp_pkg::INSTR_SET, 8'h2A, 8'h02, 32'h5555_AAAA, 8'h00, gp_pkg::STATUS_OK, 32'h0);
    do_reset(1'b1);
    cmd(8'h01, gp_pkg::INSTR_GET, 8'h2A, 8'h02, 32'h0, 8'h00, gp_pkg::STATUS_OK, 32'h5555_AAAA);
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    rst = 1'b1;
    auto_restore = 1'b1;
    do_reset(1'b1);
    s_set_get();
    s_address();
    s_store_restore();
    s_errors();
    s_boot_reload();
    stop_test();
  end

  // Watchdog: the run needs well under 5000 cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
